// File: io_expander_i2c_slave_ctrl.sv
/*
 * Serial-bus slave of a 24-bit I/O expander: address match, command pointer,
 * port registers, change interrupt; received bytes pass a small FIFO.
 * Assumes SCL/SDA/pins are asynchronous and pass two flops; rst_i combines
 * power-on reset and the synchronised reset pin.
 */
//
// Contract
// - Answer only at 7-bit address 0x22 (select low) or 0x23 (select high).
// - Address LSB 1 means read from device, 0 means write.
// - Power-on reset holds everything at defaults until released.
// - Reset pin low forces registers and bus machine to defaults.
// - Any edge on an input pin asserts interrupt after valid delay.
// - Interrupt clears on return to captured level or input-port read.
// - Read clear takes effect at rising SCL of the ack bit.
// - Output pins never interrupt; foreign bus traffic leaves interrupt alone.
// - Output-to-input change may interrupt if pin differs from captured input.
// - Interrupt is open drain: pulls low only, never drives high.
// - Write: address with 0, command byte, then any number of stored bytes.
// - Four groups of three registers; stepping wraps port 2 to 0.
// - Read: write command, repeated start, address with 1, data returned.
// - Repeated start keeps pointer at the register then being accessed.
// - With auto-step set, further read bytes come from the next register of the group.
// - Pin levels sampled into read register at rising ack clock edge.
// - First byte after write address is the command, stored in control.
// - Auto-step flag set: low pointer bits step, skipping reserved slots.
// - Auto-step flag clear: pointer stays fixed.
// - Control register resets to 00 hex.
// - Input registers return pin levels, read only.
// - Output registers read back the latch, drive only output pins.
// - Polarity bit 1 inverts the input value.
// - Configuration 1 is input, 0 is output; reset to ones.
`timescale 1ns/1ps
`default_nettype none
`include "io_expander_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
module rx_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 32
) (
    input wire logic clock_i,          // System clock
    input wire logic rst_i,            // Synchronous reset
    input wire logic [WIDTH-1:0] wr_data_i, // Write word
    input wire logic wr_valid_i,       // Write request
    output logic wr_ready_o,           // Not full
    output logic [WIDTH-1:0] rd_data_o, // Head word
    output logic rd_valid_o,           // Not empty
    input wire logic rd_ready_i        // Pop
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW:0] wp_ff;
    logic [AW:0] rp_ff;
    wire full = (wp_ff[AW] != rp_ff[AW]) && (wp_ff[AW-1:0] == rp_ff[AW-1:0]);
    wire empty = (wp_ff == rp_ff);
    wire push = wr_valid_i && !full;
    wire pop = rd_ready_i && !empty;
    assign wr_ready_o = !full;
    assign rd_valid_o = !empty;
    assign rd_data_o = mem_ff[rp_ff[AW-1:0]];

    always_ff @(posedge clock_i)
    begin
        if (push)
        begin
            mem_ff[wp_ff[AW-1:0]] <= wr_data_i;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            wp_ff <= '0;
            rp_ff <= '0;
        end
        else
        begin
            wp_ff <= wp_ff + (AW+1)'(push);
            rp_ff <= rp_ff + (AW+1)'(pop);
        end
    end
endmodule // rx_fifo

////////////////////////////////////////////////////////////////////////////////
module io_expander_i2c_slave_ctrl
    import io_expander_pkg::*;
#(
    parameter int PORTS = 3,
    parameter int IRQ_CYCLES = `IRQ_VALID_CYCLES
) (
    input wire logic clock_i,          // 40 MHz system clock
    input wire logic rst_i,            // Power-on or reset pin, active high
    input wire logic scl_i,            // Bus clock pin
    input wire logic sda_i,            // Bus data pin level
    output logic sda_o,                // Bus data drive value, always 0
    output logic sda_oe_n_o,           // Low while pulling SDA low
    input wire logic addr_sel_i,       // Address select pin
    input wire logic [8*PORTS-1:0] port_pins_i,  // Port pin levels
    output logic [8*PORTS-1:0] port_pins_o,      // Port drive values
    output logic [8*PORTS-1:0] port_pins_oe_n_o, // Low where pin is output
    output logic irq_n_o,              // Interrupt drive value, always 0
    output logic irq_oe_n_o            // Low while interrupt pulled
);
    localparam int NB = 8 * PORTS;

    function automatic logic [1:0] next_port(input logic [1:0] p);
        next_port = (p == 2'(PORTS - 1)) ? 2'h0 : p + 2'h1;
    endfunction

    // Two-flop synchronisers
    logic [2:0] s1_ff;
    logic [2:0] s2_ff;
    logic [NB-1:0] p1_ff;
    logic [NB-1:0] p2_ff;
    logic scl_d_ff;
    logic sda_d_ff;
    always_ff @(posedge clock_i)
    begin
        s1_ff <= {addr_sel_i, sda_i, scl_i};
        s2_ff <= s1_ff;
        p1_ff <= port_pins_i;
        p2_ff <= p1_ff;
        scl_d_ff <= s2_ff[0];
        sda_d_ff <= s2_ff[1];
    end
    wire scl = s2_ff[0];
    wire sda = s2_ff[1];
    wire scl_rise = scl && !scl_d_ff;
    wire scl_fall = !scl && scl_d_ff;
    wire start_cond = scl && scl_d_ff && sda_d_ff && !sda;
    wire stop_cond = scl && scl_d_ff && !sda_d_ff && sda;

    ////////////////////////////////////////////////////////////////////////////
    bus_state_e state_ff;
    bus_state_e nxt_state;
    logic [3:0] bit_ff;
    logic [7:0] shift_ff;
    logic [7:0] cmd_ff;
    logic in_ack_ff;
    logic drive_low_ff;
    logic [NB-1:0] out_ff;
    logic [NB-1:0] pol_ff;
    logic [NB-1:0] cfg_ff;
    logic [NB-1:0] in_cap_ff;
    logic rd_nack_ff;
    logic addr_ack_ff;

    wire [1:0] ptr = cmd_ff[1:0];
    wire [1:0] grp = cmd_ff[3:2];
    wire auto_step_flag = cmd_ff[`CMD_AUTO_BIT];
    wire [1:0] ptr_step = auto_step_flag ? next_port(ptr) : ptr;
    wire [NB-1:0] in_view = in_cap_ff ^ pol_ff;
    wire [NB-1:0] sel_vec = (grp == `SLOT_INPUT) ? in_view :
                            (grp == `SLOT_OUTPUT) ? out_ff :
                            (grp == `SLOT_POLARITY) ? pol_ff : cfg_ff;
    wire [7:0] rd_byte = sel_vec[ptr*8 +: 8];
    wire [7:0] rx_byte = {shift_ff[6:0], sda};
    wire addr_hit = (rx_byte[7:2] == `ADDR_UPPER6) && (rx_byte[1] == s2_ff[2]);
    wire byte_done = scl_rise && (bit_ff == 4'd7) && !in_ack_ff;
    wire ack_rise = scl_rise && in_ack_ff;
    wire read_ack = ack_rise && (state_ff == ST_RDATA) && !addr_ack_ff;
    wire rd_input = read_ack && (grp == `SLOT_INPUT);

    // Received command/data bytes queue up; writes retire one per cycle
    rx_word_s fifo_in;
    rx_word_s fifo_out;
    logic fifo_wr_ready;
    logic fifo_rd_valid;
    assign fifo_in = '{data: rx_byte, is_cmd: (state_ff == ST_CMD)};
    wire fifo_push = byte_done && fifo_wr_ready &&
                     ((state_ff == ST_CMD) || (state_ff == ST_WDATA));
    rx_fifo #(.WIDTH($bits(rx_word_s)), .DEPTH(`FIFO_DEPTH)) u_rx_fifo (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .wr_data_i(fifo_in),
        .wr_valid_i(fifo_push),
        .wr_ready_o(fifo_wr_ready),
        .rd_data_o(fifo_out),
        .rd_valid_o(fifo_rd_valid),
        .rd_ready_i(!read_ack)
    );
    // Pointer is updated by the read path too; stall retirement on that cycle
    wire retire = fifo_rd_valid && !read_ack;

    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: nxt_state = ST_IDLE;
            ST_ADDR:
                if (byte_done)
                    nxt_state = !addr_hit ? ST_SKIP : (rx_byte[0] ? ST_RDATA : ST_CMD);
            ST_CMD: if (byte_done) nxt_state = ST_WDATA;
            ST_WDATA: nxt_state = ST_WDATA;
            ST_RDATA: if (read_ack && sda) nxt_state = ST_SKIP;
            ST_SKIP: nxt_state = ST_SKIP;
            default: nxt_state = ST_IDLE;
        endcase
        if (start_cond)
            nxt_state = ST_ADDR;
        else if (stop_cond)
            nxt_state = ST_IDLE;
    end

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            state_ff <= ST_IDLE;
            bit_ff <= 4'h0;
            shift_ff <= 8'h00;
            in_ack_ff <= 1'b0;
            drive_low_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            if (start_cond || stop_cond)
            begin
                bit_ff <= 4'h0;
                in_ack_ff <= 1'b0;
                drive_low_ff <= 1'b0;
            end
            else if (scl_rise && !in_ack_ff)
            begin
                shift_ff <= rx_byte;
                bit_ff <= bit_ff + 4'h1;
                if (bit_ff == 4'd7)
                begin
                    in_ack_ff <= 1'b1;
                    bit_ff <= 4'h0;
                end
            end
            else if (ack_rise)
            begin
                in_ack_ff <= 1'b0;
            end
            if (scl_fall)
            begin
                if (in_ack_ff && (addr_ack_ff || state_ff == ST_WDATA))
                    drive_low_ff <= 1'b1; // Ack for address hit or written byte
                else if (!in_ack_ff && state_ff == ST_RDATA)
                    drive_low_ff <= !rd_byte[7 - bit_ff[2:0]];
                else
                    drive_low_ff <= 1'b0;
            end
        end
    end

    // Address acknowledge of a matched frame: the slave drives it, and in a
    // read it is not a data acknowledge, so the pointer must not step on it
    always_ff @(posedge clock_i)
    begin
        if (rst_i || start_cond || stop_cond || ack_rise)
        begin
            addr_ack_ff <= 1'b0;
        end
        else if (byte_done && (state_ff == ST_ADDR) && addr_hit)
        begin
            addr_ack_ff <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Command and register file
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            cmd_ff <= `CMD_RESET;
            out_ff <= {PORTS{`OUTPUT_RESET}};
            pol_ff <= {PORTS{`POLARITY_RESET}};
            cfg_ff <= {PORTS{`CONFIG_RESET}};
        end
        else if (read_ack)
        begin
            cmd_ff[1:0] <= ptr_step;
        end
        else if (retire)
        begin
            if (fifo_out.is_cmd)
                cmd_ff <= fifo_out.data;
            else
            begin
                case (grp)
                    `SLOT_OUTPUT: out_ff[ptr*8 +: 8] <= fifo_out.data;
                    `SLOT_POLARITY: pol_ff[ptr*8 +: 8] <= fifo_out.data;
                    `SLOT_CONFIG: cfg_ff[ptr*8 +: 8] <= fifo_out.data;
                    default: ;
                endcase
                cmd_ff[1:0] <= ptr_step;
            end
        end
    end

    // Input register holds raw pin levels, taken at reset release and at each
    // input-port read ack; polarity applies only on the way out, so a
    // polarity write never looks like a pin edge.
    localparam int DW = $clog2(IRQ_CYCLES + 1);
    logic [DW-1:0] dly_ff;
    logic irq_ff;
    wire [NB-1:0] is_input = cfg_ff;
    wire [NB-1:0] diff = (p2_ff ^ in_cap_ff) & is_input;
    logic [NB-1:0] rd_mask;
    always_comb
    begin
        rd_mask = '0;
        rd_mask[ptr*8 +: 8] = 8'hff;
    end

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
            rd_nack_ff <= 1'b1;
        else
            rd_nack_ff <= 1'b0;
        if (rd_nack_ff || rd_input)
            in_cap_ff <= rd_nack_ff ? p2_ff :
                         ((in_cap_ff & ~rd_mask) | (p2_ff & rd_mask));
    end

    // Interrupt stands while any input differs from its captured level;
    // assertion waits the valid delay so a brief glitch can not flag.
    wire any_diff = |diff;
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            dly_ff <= '0;
            irq_ff <= 1'b0;
        end
        else if (!any_diff || rd_input)
        begin
            dly_ff <= '0;
            irq_ff <= 1'b0;
        end
        else if (dly_ff < DW'(IRQ_CYCLES))
            dly_ff <= dly_ff + DW'(1);
        else
            irq_ff <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            sda_oe_n_o <= 1'b1;
            irq_oe_n_o <= 1'b1;
            port_pins_o <= {PORTS{`OUTPUT_RESET}};
            port_pins_oe_n_o <= {PORTS{`CONFIG_RESET}};
        end
        else
        begin
            sda_oe_n_o <= !drive_low_ff;
            irq_oe_n_o <= !irq_ff;
            port_pins_o <= out_ff;
            port_pins_oe_n_o <= cfg_ff;
        end
    end
    always_ff @(posedge clock_i)
    begin
        sda_o <= 1'b0;
        irq_n_o <= 1'b0;
    end
endmodule // io_expander_i2c_slave_ctrl

`default_nettype wire

// File: io_expander_cfg.svh
/*
 * Constants for the serial I/O expander slave: bus address, register slots,
 * reset values, timing counts.
 * Assumes a 40 MHz system clock; included by its bare name.
 */
`ifndef IO_EXPANDER_CFG_SVH
`define IO_EXPANDER_CFG_SVH

`define ADDR_UPPER6 6'h11
`define SLOT_INPUT 2'h0
`define SLOT_OUTPUT 2'h1
`define SLOT_POLARITY 2'h2
`define SLOT_CONFIG 2'h3
`define CMD_AUTO_BIT 7
`define CMD_RESET 8'h00
`define OUTPUT_RESET 8'hff
`define POLARITY_RESET 8'h00
`define CONFIG_RESET 8'hff
`define CLK_PERIOD_NS 25
`define IRQ_VALID_DELAY_NS 4000
`define IRQ_VALID_CYCLES (`IRQ_VALID_DELAY_NS / `CLK_PERIOD_NS)
`define FIFO_DEPTH 32

`endif

// File: io_expander_pkg.sv
/*
 * Types shared by the I/O expander slave and its receive buffer.
 * Assumes the constants header is available.
 */
`default_nettype none

package io_expander_pkg;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_ADDR = 6'h02,
        ST_CMD = 6'h04,
        ST_WDATA = 6'h08,
        ST_RDATA = 6'h10,
        ST_SKIP = 6'h20
    } bus_state_e;

    typedef struct packed {
        logic [7:0] data;
        logic is_cmd;
    } rx_word_s;

endpackage

`default_nettype wire

// File: io_expander_props.sv
/* Port checker for the expander slave.
   Assumes it is bound onto io_expander_i2c_slave_ctrl. */
`timescale 1ns/1ps
`default_nettype none
module io_expander_props #(
    parameter int PORTS = 3,
    parameter int IRQ_CYCLES = 2
) (
    input wire logic clock_i, // Clock
    input wire logic rst_i, // Reset
    input wire logic scl_i, // Bus clock
    input wire logic sda_i, // Bus data
    input wire logic sda_o, // Data drive
    input wire logic sda_oe_n_o, // Data enable
    input wire logic addr_sel_i, // Address select
    input wire logic [8*PORTS-1:0] port_pins_i, // Pin levels
    input wire logic [8*PORTS-1:0] port_pins_o, // Latch
    input wire logic [8*PORTS-1:0] port_pins_oe_n_o, // Direction
    input wire logic irq_n_o, // Irq drive
    input wire logic irq_oe_n_o // Irq enable
);
    localparam int LATE = IRQ_CYCLES + 12;
    logic [8*PORTS-1:0] pins_d_ff;
    logic scl_d_ff;
    logic [7:0] quiet_ff; // Cycles since any pin moved
    logic [7:0] scl_up_ff; // Cycles since bus clock rose
    always_ff @(posedge clock_i)
    begin
        pins_d_ff <= port_pins_i;
        scl_d_ff <= scl_i;
        quiet_ff <= (rst_i || pins_d_ff != port_pins_i) ? 8'h00 : quiet_ff + 8'(quiet_ff != 8'hff);
        scl_up_ff <= (rst_i || (scl_i && !scl_d_ff)) ? 8'h00 : scl_up_ff + 8'(scl_up_ff != 8'hff);
    end
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    a_irq_drive_low: assert property (!irq_oe_n_o |-> irq_n_o == 1'b0)
        else $error("interrupt pin driven high");
    a_reset_defaults: assert property ($fell(rst_i) |-> &port_pins_o && &port_pins_oe_n_o
        && irq_oe_n_o && sda_oe_n_o) else $error("outputs not at defaults after reset");
    a_irq_not_early: assert property ($fell(irq_oe_n_o) |-> quiet_ff >= IRQ_CYCLES)
        else $error("interrupt before valid delay");
    a_irq_needs_change: assert property ($fell(irq_oe_n_o) |-> quiet_ff <= LATE)
        else $error("interrupt without recent pin change");
    a_irq_clear_cause: assert property ($rose(irq_oe_n_o) |-> quiet_ff <= LATE || scl_up_ff <= 8'h0c)
        else $error("interrupt cleared without cause");
    a_sda_high_stable: assert property ($rose(scl_i) |-> ##2 $stable(sda_oe_n_o) [*2])
        else $error("data drive moved while clock high");
    a_latch_needs_ack: assert property ($changed(port_pins_o) |-> ##[0:20] !sda_oe_n_o)
        else $error("output latch changed without acknowledge");
    a_dir_needs_ack: assert property ($changed(port_pins_oe_n_o) |-> ##[0:20] !sda_oe_n_o)
        else $error("direction changed without acknowledge");
    c_irq_set: cover property ($fell(irq_oe_n_o));
    c_irq_clear: cover property ($rose(irq_oe_n_o));
    c_latch_write: cover property ($changed(port_pins_o));
endmodule // io_expander_props
bind io_expander_i2c_slave_ctrl io_expander_props #(.PORTS(PORTS), .IRQ_CYCLES(IRQ_CYCLES)) props_inst (
    .clock_i, .rst_i, .scl_i, .sda_i, .sda_o, .sda_oe_n_o, .addr_sel_i, .port_pins_i,
    .port_pins_o, .port_pins_oe_n_o, .irq_n_o, .irq_oe_n_o);
`default_nettype wire

// File: io_expander_bus_master.sv
/* Behavioural serial-bus master for the expander bench.
   Assumes the bench resolves the data line with a pull-up. */
`timescale 1ns/1ps
`default_nettype none
module io_expander_bus_master (
    input wire logic sda_i, // Resolved data line
    output logic scl_o, // Bus clock, idles high
    output logic sda_o // Data drive, 1 releases
);
    initial
    begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    // Slave is sampled mid-high so its synchroniser latency fits the low phase
    task automatic bit_xfer(input logic b, output logic r);
        sda_o = b;
        #50;
        scl_o = 1'b1;
        #50;
        r = sda_i;
        #50;
        scl_o = 1'b0;
        #50;
    endtask
    task automatic start();
        sda_o = 1'b1;
        #57;
        scl_o = 1'b1;
        #100;
        sda_o = 1'b0;
        #100;
        scl_o = 1'b0;
        #50;
    endtask
    task automatic stop();
        sda_o = 1'b0;
        #50;
        scl_o = 1'b1;
        #100;
        sda_o = 1'b1;
        #100;
    endtask
    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_xfer(b[i], r);
        bit_xfer(1'b1, r);
        ack = !r;
    endtask
    task automatic get_byte(input logic last, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_xfer(1'b1, b[i]);
        bit_xfer(last, r);
    endtask
endmodule // io_expander_bus_master
`default_nettype wire

// File: io_expander_i2c_slave_ctrl_bench.sv
/* Self-checking bench for the expander slave.
   Assumes the master model and checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module io_expander_i2c_slave_ctrl_bench;
    localparam int IRQ = 2;
    logic clock_i, rst_i, addr_sel_i, sda_o, sda_oe_n_o, irq_n_o, irq_oe_n_o, m_scl, m_sda, ack;
    logic [23:0] ext_ff, pins_o, oe_n, got;
    logic [6:0] dev;
    int errors = 0;
    int n_compared = 0;
    wire logic sda_line = m_sda & (sda_oe_n_o | sda_o);
    wire logic irq_line = irq_oe_n_o | irq_n_o;
    // Output pins show the latch, inputs show what the outside drives
    wire logic [23:0] pin_level = (oe_n & ext_ff) | (~oe_n & pins_o);
    io_expander_i2c_slave_ctrl #(.PORTS(3), .IRQ_CYCLES(IRQ)) io_expander_i2c_slave_ctrl_inst (
        .clock_i(clock_i), .rst_i(rst_i), .scl_i(m_scl), .sda_i(sda_line), .sda_o(sda_o),
        .sda_oe_n_o(sda_oe_n_o), .addr_sel_i(addr_sel_i), .port_pins_i(pin_level),
        .port_pins_o(pins_o), .port_pins_oe_n_o(oe_n), .irq_n_o(irq_n_o), .irq_oe_n_o(irq_oe_n_o));
    io_expander_bus_master io_expander_bus_master_inst (.sda_i(sda_line), .scl_o(m_scl), .sda_o(m_sda));
    initial
    begin
        clock_i = 1'b0;
        forever #12.5 clock_i = ~clock_i;
    end
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        if (errors == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic frame_wr(input logic [7:0] cmd, input logic [23:0] d, input int n, input logic a);
        io_expander_bus_master_inst.start();
        io_expander_bus_master_inst.put_byte({dev, 1'b0}, ack);
        check(24'(ack), 24'(a));
        io_expander_bus_master_inst.put_byte(cmd, ack);
        for (int i = 0; i < n; i++)
        begin
            io_expander_bus_master_inst.put_byte(d[8*i +: 8], ack);
            check(24'(ack), 24'(a));
        end
        io_expander_bus_master_inst.stop();
    endtask
    task automatic frame_rd(input logic [7:0] cmd, input int n, output logic [23:0] q);
        q = 24'h000000;
        io_expander_bus_master_inst.start();
        io_expander_bus_master_inst.put_byte({dev, 1'b0}, ack);
        io_expander_bus_master_inst.put_byte(cmd, ack);
        io_expander_bus_master_inst.start();
        io_expander_bus_master_inst.put_byte({dev, 1'b1}, ack);
        check(24'(ack), 24'h000001);
        for (int i = 0; i < n; i++)
            io_expander_bus_master_inst.get_byte(i == n - 1, q[8*i +: 8]);
        io_expander_bus_master_inst.stop();
    endtask
    task automatic pins_set(input logic [23:0] v);
        @(posedge clock_i);
        ext_ff <= v;
        repeat (IRQ + 20) @(posedge clock_i);
    endtask
    task automatic t_reset_state();
        check(pins_o, 24'hffffff);
        check(oe_n, 24'hffffff);
        check(24'(irq_line), 24'h000001);
    endtask
    task automatic t_read_input();
        frame_rd(8'h82, 2, got);
        check(got, 24'h00965a);
    endtask
    task automatic t_write_output();
        frame_wr(8'h86, 24'hc3b2a1, 3, 1'b1);
        check(pins_o, 24'ha1c3b2);
        frame_rd(8'h04, 2, got);
        check(got, 24'h00b2b2);
    endtask
    task automatic t_foreign();
        dev = 7'h23;
        frame_wr(8'h84, 24'h0000ff, 1, 1'b0);
        check(pins_o, 24'ha1c3b2);
        @(posedge clock_i);
        addr_sel_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        frame_wr(8'h0c, 24'h000000, 1, 1'b1);
        check(oe_n, 24'hffff00);
    endtask
    task automatic t_irq();
        pins_set(24'h5a3c97);
        check(24'(irq_line), 24'h000001);
        pins_set(24'h5a3d97);
        check(24'(irq_line), 24'h000000);
        pins_set(24'h5a3c97);
        check(24'(irq_line), 24'h000001);
        pins_set(24'h5a3d97);
        frame_rd(8'h01, 1, got);
        check(got, 24'h00003c);
        check(24'(irq_line), 24'h000001);
    endtask
    task automatic t_polarity();
        frame_wr(8'h0a, 24'h0000ff, 1, 1'b1);
        frame_rd(8'h02, 1, got);
        check(got, 24'h0000a5);
        check(24'(irq_line), 24'h000001);
    endtask
    initial
    begin
        rst_i = 1'b1;
        addr_sel_i = 1'b0;
        ext_ff = 24'h5a3c96;
        dev = 7'h22;
        repeat (16) @(posedge clock_i);
        rst_i <= 1'b0;
        repeat (8) @(posedge clock_i);
        t_reset_state();
        t_read_input();
        t_write_output();
        t_foreign();
        t_irq();
        t_polarity();
        end_sim();
    end
    initial
    begin
        #200us;
        errors++;
        end_sim();
    end
endmodule // io_expander_i2c_slave_ctrl_bench
`default_nettype wire
